// ===== pmm_defs.svh
// constants for the program and data memory map block
//
// Contract
// RULE1: the program counter is 13 bits wide and spans 8K words of 14 bits.
// RULE2: only program words 0000h to 07FFh exist as storage.
// RULE3: a program access above the 2K implemented words wraps into those 2K words.
// RULE4: after any reset instruction fetch starts at 0000h.
// RULE5: taking an interrupt loads the program counter with 0004h.
// RULE6: data memory has four banks and special function registers fill the first 32 of each.
// RULE7: bank 0 addresses 40h to 6Fh are general purpose static RAM.
// RULE8: addresses 70h to 7Fh of every bank reach the same 16 common RAM bytes.
// RULE9: reading any data location without RAM behind it returns zero.
// RULE10: the two bank select bits of core status choose bank 0 to 3 as a binary number.
// RULE11: the general purpose file holds 64 bytes, reachable directly and via the pointer.
// RULE12: the core registers answer at the same low address in every bank.
// RULE13: a direct access address is the two bank select bits joined to the 7-bit address.
`ifndef PMM_DEFS_SVH
`define PMM_DEFS_SVH

// ----------------------------------------------------------------------------
// core register offsets within every bank
// ----------------------------------------------------------------------------
`define PMM_OFS_INDIRECT  7'h00
`define PMM_OFS_PC_LOW    7'h02
`define PMM_OFS_STATUS    7'h03
`define PMM_OFS_POINTER   7'h04
`define PMM_OFS_PC_LATCH  7'h0a
`define PMM_OFS_INT_CTRL  7'h0b

// ----------------------------------------------------------------------------
// data map boundaries
// ----------------------------------------------------------------------------
`define PMM_SFR_LAST      7'h1f
`define PMM_GPR_FIRST     7'h40
`define PMM_GPR_LAST      7'h6f
`define PMM_COMMON_FIRST  7'h70
`define PMM_COMMON_BASE   6'h30

// ----------------------------------------------------------------------------
// core status fields and reset values
// ----------------------------------------------------------------------------
`define PMM_ST_IND_BANK   7
`define PMM_ST_BANK_HI    6
`define PMM_ST_BANK_LO    5
`define PMM_ST_WR_MASK    8'he7
`define PMM_ST_RESET      8'h18
`define PMM_PTR_RESET     8'h00
`define PMM_LATCH_RESET   5'h00
`define PMM_INTC_RESET    8'h00

// ----------------------------------------------------------------------------
// program vectors
// ----------------------------------------------------------------------------
`define PMM_RESET_VECTOR  13'h0000
`define PMM_IRQ_VECTOR    13'h0004

`endif

// ===== pmm_pkg.sv
// types shared by the memory map block
package pmm_pkg;
	typedef logic [12:0] pmm_pc_t;
	typedef logic [8:0]  pmm_daddr_t;
	typedef logic [7:0]  pmm_byte_t;
	typedef logic [5:0]  pmm_idx_t;

	// where a data address lands
	typedef enum logic [3:0] {
		PMM_REG_SFR    = 4'b0001,
		PMM_REG_GPR    = 4'b0010,
		PMM_REG_COMMON = 4'b0100,
		PMM_REG_NONE   = 4'b1000
	} pmm_region_t;
endpackage : pmm_pkg

// ===== pmm_mem_if.sv
// link between the map decoder and its storage
`timescale 1ns/1ps
`default_nettype none
interface pmm_mem_if;
	logic                wr;
	logic                rd;
	logic                ram_sel;
	pmm_pkg::pmm_idx_t   idx;
	pmm_pkg::pmm_byte_t  wdata;
	pmm_pkg::pmm_byte_t  bypass;
	pmm_pkg::pmm_byte_t  rdata;

	modport ctl (output wr, output rd, output ram_sel, output idx, output wdata,
		output bypass, input rdata);
	modport mem (input wr, input rd, input ram_sel, input idx, input wdata,
		input bypass, output rdata);
endinterface : pmm_mem_if
`default_nettype wire

// ===== pmm_ram.sv
// general purpose file storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module pmm_ram #(
	parameter int DEPTH = 64
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic resetn_i,
	// decoder side
	pmm_mem_if.mem    bus
);
	import pmm_pkg::*;

	if (DEPTH < 64 || DEPTH > 64) begin : g_bad_depth
		$error("pmm_ram: depth must be 64");
	end

	pmm_byte_t mem [DEPTH];
	pmm_byte_t rdata;
	pmm_byte_t next_rdata;

	// ------------------------------------------------------------------------
	// read path
	// ------------------------------------------------------------------------
	// non-ram reads take the decoder's value so one flop drives read data
	always_comb begin
		next_rdata = 8'h00;
		if (bus.rd) begin
			next_rdata = bus.ram_sel ? mem[bus.idx] : bus.bypass;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// storage holds its contents across reset
	always_ff @(posedge clk_i) begin
		if (bus.wr && bus.ram_sel) begin
			mem[bus.idx] <= bus.wdata; // RULE11
		end
	end

	assign bus.rdata = rdata;
endmodule : pmm_ram
`default_nettype wire

// ===== pmm_top.sv
// program counter reach and banked data memory map
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pmm_defs.svh"
module pmm_top #(
	parameter int PC_W   = 13,
	parameter int IMPL_W = 11,
	parameter int DEPTH  = 64
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	// program fetch
	input  wire logic             pc_inc_i,
	input  wire logic             jump_i,
	input  wire logic [10:0]      jump_target_i,
	input  wire logic             irq_take_i,
	output var  pmm_pkg::pmm_pc_t pc_o,
	output var  logic [10:0]      fetch_addr_o,
	// operand access
	input  wire logic [6:0]       addr_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	input  wire logic [7:0]       wdata_i,
	output var  logic [7:0]       rdata_o,
	// core state
	output var  logic [7:0]       status_o,
	output var  logic [7:0]       int_ctrl_o
);
	import pmm_pkg::*;

	if (PC_W != 13 || IMPL_W != 11 || DEPTH != 64) begin : g_bad_size
		$error("pmm_top: only a 13-bit counter, 2K words and 64 bytes are served");
	end

	// ------------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------------
	function automatic pmm_region_t region_of(input pmm_daddr_t a);
		pmm_region_t r;
		r = PMM_REG_NONE; // RULE9
		if (a[6:0] <= `PMM_SFR_LAST) begin
			r = PMM_REG_SFR; // RULE6
		end else if (a[6:0] >= `PMM_COMMON_FIRST) begin
			r = PMM_REG_COMMON; // RULE8
		end else if (a[8:7] == 2'b00 && a[6:0] >= `PMM_GPR_FIRST) begin
			r = PMM_REG_GPR; // RULE7
		end
		return r;
	endfunction : region_of

	function automatic pmm_idx_t index_of(input pmm_daddr_t a);
		pmm_idx_t i;
		i = 6'(a[6:0] - `PMM_GPR_FIRST);
		if (a[6:0] >= `PMM_COMMON_FIRST) begin
			i = `PMM_COMMON_BASE | {2'b00, a[3:0]}; // RULE8
		end
		return i;
	endfunction : index_of

	pmm_mem_if mem_bus ();

	pmm_pc_t     pc;
	pmm_pc_t     next_pc;
	logic [10:0] fetch;
	logic [10:0] next_fetch;
	logic [7:0]  status;
	logic [7:0]  next_status;
	logic [7:0]  pointer;
	logic [7:0]  next_pointer;
	logic [4:0]  pc_latch;
	logic [4:0]  next_pc_latch;
	logic [7:0]  int_ctrl;
	logic [7:0]  next_int_ctrl;

	logic        indirect;
	pmm_daddr_t  eff_addr;
	pmm_region_t region;
	logic        pc_low_wr;
	logic [1:0]  bank;
	logic [7:0]  sfr_rdata;

	assign bank     = {status[`PMM_ST_BANK_HI], status[`PMM_ST_BANK_LO]};
	assign indirect = (addr_i == `PMM_OFS_INDIRECT);

	// ------------------------------------------------------------------------
	// effective data address
	// ------------------------------------------------------------------------
	// a pointer aimed back at the indirect port lands on a register that
	// reads zero and ignores writes, so nesting cannot loop
	always_comb begin
		if (indirect) begin
			eff_addr = {status[`PMM_ST_IND_BANK], pointer}; // RULE11
		end else begin
			eff_addr = {bank, addr_i}; // RULE13 RULE10
		end
		region = region_of(eff_addr);
	end

	assign pc_low_wr = wr_i && region == PMM_REG_SFR && eff_addr[6:0] == `PMM_OFS_PC_LOW;

	// ------------------------------------------------------------------------
	// core register read value, same in every bank
	// ------------------------------------------------------------------------
	always_comb begin
		sfr_rdata = 8'h00;
		if (region == PMM_REG_SFR) begin
			unique case (eff_addr[6:0]) // RULE12
				`PMM_OFS_PC_LOW:   sfr_rdata = pc[7:0];
				`PMM_OFS_STATUS:   sfr_rdata = status;
				`PMM_OFS_POINTER:  sfr_rdata = pointer;
				`PMM_OFS_PC_LATCH: sfr_rdata = {3'b000, pc_latch};
				`PMM_OFS_INT_CTRL: sfr_rdata = int_ctrl;
				default:           sfr_rdata = 8'h00;
			endcase
		end
	end

	assign mem_bus.wr      = wr_i;
	assign mem_bus.rd      = rd_i;
	assign mem_bus.ram_sel = (region == PMM_REG_GPR) || (region == PMM_REG_COMMON);
	assign mem_bus.idx     = index_of(eff_addr);
	assign mem_bus.wdata   = wdata_i;
	assign mem_bus.bypass  = sfr_rdata; // RULE9

	pmm_ram #(
		.DEPTH (DEPTH)
	) u_ram (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.bus      (mem_bus)
	);

	// ------------------------------------------------------------------------
	// core register writes
	// ------------------------------------------------------------------------
	always_comb begin
		next_status   = status;
		next_pointer  = pointer;
		next_pc_latch = pc_latch;
		next_int_ctrl = int_ctrl;
		if (wr_i && region == PMM_REG_SFR) begin
			unique case (eff_addr[6:0]) // RULE12
				`PMM_OFS_STATUS: begin
					// time-out and power-down flags stay read only
					next_status = (status & ~`PMM_ST_WR_MASK) | (wdata_i & `PMM_ST_WR_MASK); // RULE10
				end
				`PMM_OFS_POINTER:  next_pointer  = wdata_i;
				`PMM_OFS_PC_LATCH: next_pc_latch = wdata_i[4:0];
				`PMM_OFS_INT_CTRL: next_int_ctrl = wdata_i;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			status   <= `PMM_ST_RESET;
			pointer  <= `PMM_PTR_RESET;
			pc_latch <= `PMM_LATCH_RESET;
			int_ctrl <= `PMM_INTC_RESET;
		end else begin
			status   <= next_status;
			pointer  <= next_pointer;
			pc_latch <= next_pc_latch;
			int_ctrl <= next_int_ctrl;
		end
	end

	// ------------------------------------------------------------------------
	// program counter
	// ------------------------------------------------------------------------
	// interrupt wins over a write of the low byte, which wins over a jump
	always_comb begin
		next_pc = pc;
		if (irq_take_i) begin
			next_pc = `PMM_IRQ_VECTOR; // RULE5
		end else if (pc_low_wr) begin
			next_pc = {pc_latch, wdata_i};
		end else if (jump_i) begin
			next_pc = {pc_latch[4:3], jump_target_i};
		end else if (pc_inc_i) begin
			next_pc = 13'(pc + 13'h0001); // RULE1
		end
		// upper counter bits have no storage behind them
		next_fetch = next_pc[10:0]; // RULE2 RULE3
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pc    <= `PMM_RESET_VECTOR; // RULE4
			fetch <= 11'h000;
		end else begin
			pc    <= next_pc;
			fetch <= next_fetch;
		end
	end

	assign pc_o         = pc;
	assign fetch_addr_o = fetch;
	assign rdata_o      = mem_bus.rdata;
	assign status_o     = status;
	assign int_ctrl_o   = int_ctrl;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence seq_ram_write;
		wr_i && mem_bus.ram_sel;
	endsequence

	sequence seq_ram_read_same;
		rd_i && !wr_i && mem_bus.ram_sel && mem_bus.idx == $past(mem_bus.idx);
	endsequence

	property p_ram_roundtrip;
		seq_ram_write ##1 seq_ram_read_same |=> rdata_o == $past(wdata_i, 2);
	endproperty

	chk_pc_reset_vec: assert property (disable iff (1'b0) // RULE4
		!resetn_i ##1 resetn_i |-> pc_o == 13'h0000 && fetch_addr_o == 11'h000)
		else $error("fetch does not start at zero after reset");

	chk_irq_vector: assert property (irq_take_i |=> pc_o == 13'h0004) // RULE5
		else $error("interrupt did not load vector");

	chk_fetch_wrap: assert property (fetch_addr_o == pc_o[10:0]) // RULE3
		else $error("fetch address does not wrap into 2K");

	chk_pc_rollover: assert property (pc_inc_i && !irq_take_i && !jump_i && !pc_low_wr // RULE1
		&& pc_o == 13'h1fff |=> pc_o == 13'h0000)
		else $error("counter is not 13 bits wide");

	chk_unimpl_zero: assert property (rd_i && region == PMM_REG_NONE |=> rdata_o == 8'h00) // RULE9
		else $error("unimplemented location read nonzero");

	chk_common_mirror: assert property (region == PMM_REG_COMMON // RULE8
		|-> mem_bus.idx == {2'b11, eff_addr[3:0]})
		else $error("common ram not shared across banks");

	chk_gpr_roundtrip: assert property (p_ram_roundtrip) // RULE11
		else $error("ram byte not read back");

	chk_bank_write: assert property (wr_i && !indirect && addr_i == 7'h03 // RULE10
		|=> bank == $past(wdata_i[6:5]))
		else $error("bank select not taken from status write");

	chk_core_mirror: assert property (rd_i && region == PMM_REG_SFR // RULE12
		&& eff_addr[6:0] == 7'h04 |=> rdata_o == $past(pointer))
		else $error("pointer not seen in this bank");

	chk_direct_addr: assert property (!indirect |-> eff_addr == {bank, addr_i}) // RULE13
		else $error("direct address not formed from bank bits");

	chk_gpr_bank0: assert property (region == PMM_REG_GPR // RULE7
		|-> bank == 2'b00 || indirect)
		else $error("general ram seen outside bank 0");

	chk_sfr_span: assert property (eff_addr[6:0] < 7'h20 |-> region == PMM_REG_SFR) // RULE6
		else $error("first 32 locations not special registers");

	// a read answers for one cycle only, so a stale byte never looks fresh
	chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00) // RULE9
		else $error("read data did not return to zero");

	chk_reset_state: assert property (disable iff (1'b0) // RULE4
		!resetn_i |=> pc_o == 13'h0000 && rdata_o == 8'h00)
		else $error("reset did not clear counter and read data");

	chk_jump_page: assert property (jump_i && !irq_take_i && !pc_low_wr // RULE1
		|=> pc_o == {$past(pc_latch[4:3]), $past(jump_target_i)})
		else $error("jump did not use latch page bits");

	chk_pc_low_load: assert property (pc_low_wr && !irq_take_i // RULE12
		|=> pc_o == {$past(pc_latch), $past(wdata_i)})
		else $error("low byte write did not load full counter");

	chk_pc_hold: assert property (!irq_take_i && !pc_low_wr && !jump_i && !pc_inc_i // RULE1
		|=> $stable(pc_o))
		else $error("counter moved without a request");

	chk_status_ro: assert property (wr_i && region == PMM_REG_SFR // RULE10
		&& eff_addr[6:0] == 7'h03 |=> status_o[4:3] == $past(status[4:3]))
		else $error("read only status bits changed on write");

	chk_indirect_addr: assert property (indirect // RULE11
		|-> eff_addr == {status[`PMM_ST_IND_BANK], pointer})
		else $error("indirect address not formed from pointer");

	chk_gpr_index: assert property (region == PMM_REG_GPR |-> mem_bus.idx < 6'h30) // RULE7
		else $error("general ram index overlaps common ram");
endmodule : pmm_top
`default_nettype wire

// ===== pmm_cpu.sv
// processor side model: drives fetch control and operand strobes, notes expectations
`timescale 1ns/1ps
`default_nettype none
module pmm_cpu (
	// clock
	input  wire logic        clk_i,
	// fetch control
	output var  logic        resetn_o,
	output var  logic        pc_inc_o,
	output var  logic        jump_o,
	output var  logic [10:0] jump_target_o,
	output var  logic        irq_take_o,
	output var  logic        pc_mark_o,
	// operand access
	output var  logic [6:0]  addr_o,
	output var  logic        wr_o,
	output var  logic        rd_o,
	output var  logic [7:0]  wdata_o
);
	import pmm_pkg::*;
	pmm_byte_t byte_q[$];
	pmm_pc_t   pc_q[$];
	initial begin
		{resetn_o, pc_inc_o, jump_o, jump_target_o, irq_take_o, pc_mark_o} = '0;
		{addr_o, wr_o, rd_o, wdata_o} = '0;
	end
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic hold_reset();
		@(posedge clk_i);
		resetn_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_o <= 1'b1;
	endtask : hold_reset
	// released address and data are inverted so a stale value never looks valid
	task automatic bus(input logic w, input logic [6:0] a, input pmm_byte_t d);
		@(posedge clk_i);
		wr_o    <= w;
		rd_o    <= ~w;
		addr_o  <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o    <= 1'b0;
		rd_o    <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask : bus
	task automatic write(input logic [6:0] a, input pmm_byte_t d);
		bus(1'b1, a, d);
	endtask : write
	task automatic read(input logic [6:0] a, input pmm_byte_t e);
		byte_q.push_back(e);
		bus(1'b0, a, ~e);
	endtask : read
	// write then read the same byte with no gap between the strobes
	task automatic write_read(input logic [6:0] a, input pmm_byte_t d);
		byte_q.push_back(d);
		@(posedge clk_i);
		wr_o    <= 1'b1;
		addr_o  <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o    <= 1'b0;
		rd_o    <= 1'b1;
		wdata_o <= ~d;
		@(posedge clk_i);
		rd_o    <= 1'b0;
		addr_o  <= ~a;
	endtask : write_read
	task automatic pc_op(input logic i, input logic j, input logic [10:0] t,
		input logic q, input pmm_pc_t e);
		pc_q.push_back(e);
		@(posedge clk_i);
		{pc_inc_o, jump_o, jump_target_o, irq_take_o, pc_mark_o} <= {i, j, t, q, 1'b1};
		@(posedge clk_i);
		{pc_inc_o, jump_o, jump_target_o, irq_take_o, pc_mark_o} <= {2'b00, ~t, 2'b00};
	endtask : pc_op
endmodule : pmm_cpu
`default_nettype wire

// ===== pmm_top_bench.sv
// self-checking bench for the memory map block
`timescale 1ns/1ps
`default_nettype none
module pmm_top_bench;
	import pmm_pkg::*;
	logic        clk_i = 1'b0;
	logic        resetn, pc_inc, jump, irq_take, pc_mark, wr, rd;
	logic [10:0] jump_target, fetch_addr;
	logic [6:0]  addr;
	logic [7:0]  wdata, rdata, status, int_ctrl;
	pmm_pc_t     pc;
	int          errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	logic        rd_seen = 1'b0;
	logic        mark_seen = 1'b0;
	logic        armed = 1'b0;
	always #25 clk_i = ~clk_i;
	pmm_cpu i_pmm_cpu (.clk_i(clk_i), .resetn_o(resetn), .pc_inc_o(pc_inc), .jump_o(jump),
		.jump_target_o(jump_target), .irq_take_o(irq_take), .pc_mark_o(pc_mark),
		.addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
	pmm_top i_pmm_top (.clk_i(clk_i), .resetn_i(resetn), .pc_inc_i(pc_inc), .jump_i(jump),
		.jump_target_i(jump_target), .irq_take_i(irq_take), .pc_o(pc),
		.fetch_addr_o(fetch_addr), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
		.rdata_o(rdata), .status_o(status), .int_ctrl_o(int_ctrl));
	// ----------------------------------------
	// compares and verdict
	// ----------------------------------------
	task automatic cmp_byte(input pmm_byte_t got, input pmm_byte_t exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_byte
	task automatic cmp_pc(input pmm_pc_t got, input pmm_pc_t exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_pc
	task automatic complete_run();
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// watcher: old output values are read at the edge after the request
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rd_seen)
			cmp_byte(rdata, i_pmm_cpu.byte_q.pop_front());
		else if (armed)
			cmp_byte(rdata, 8'h00);
		if (mark_seen) begin
			cmp_pc(pc, i_pmm_cpu.pc_q[0]);
			cmp_pc({2'b00, fetch_addr}, i_pmm_cpu.pc_q.pop_front() & 13'h07ff);
		end
		rd_seen   <= rd & resetn;
		mark_seen <= pc_mark & resetn;
		armed     <= resetn;
		cycles    <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			complete_run();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		pmm_byte_t gm [64];
		int        k;
		void'($urandom(10046));
		i_pmm_cpu.hold_reset();
		i_pmm_cpu.pc_op(1'b0, 1'b0, 11'h000, 1'b0, 13'h0000);
		i_pmm_cpu.read(7'h03, 8'h18);
		for (k = 0; k < 64; k++) begin
			gm[k] = 8'($urandom);
			i_pmm_cpu.write(7'h40 + 7'(k), gm[k]);
		end
		for (k = 0; k < 64; k++)
			i_pmm_cpu.read(7'h40 + 7'(k), gm[k]);
		for (k = 0; k < 4; k++) begin
			i_pmm_cpu.write(7'h03, {1'b0, 2'(k), 5'h07});
			@(negedge clk_i);
			cmp_byte(status, {1'b0, 2'(k), 5'h1f});
			i_pmm_cpu.read(7'h03, {1'b0, 2'(k), 5'h1f});
			i_pmm_cpu.read(7'h70 + 7'(k * 3), gm[48 + k * 3]);
			i_pmm_cpu.read(7'h40, (k == 0) ? gm[0] : 8'h00);
			i_pmm_cpu.read(7'h1f, 8'h00);
			i_pmm_cpu.write(7'h04, 8'h30 + 8'(k));
			i_pmm_cpu.read(7'h04, 8'h30 + 8'(k));
			i_pmm_cpu.write(7'h0a, 8'hf0 | 8'(k));
			i_pmm_cpu.read(7'h0a, 8'h10 | 8'(k));
			i_pmm_cpu.write(7'h0b, 8'h80 | 8'(k));
			@(negedge clk_i);
			cmp_byte(int_ctrl, 8'h80 | 8'(k));
			i_pmm_cpu.read(7'h0b, 8'h80 | 8'(k));
			i_pmm_cpu.write(7'h40, (k == 0) ? gm[0] : ~gm[0]);
			i_pmm_cpu.write(7'h7f, 8'ha0 | 8'(k));
		end
		i_pmm_cpu.write(7'h03, 8'h00);
		i_pmm_cpu.read(7'h7f, 8'ha3);
		i_pmm_cpu.read(7'h40, gm[0]);
		// indirect path through the pointer, bank bit 7 clear
		i_pmm_cpu.write(7'h04, 8'h45);
		i_pmm_cpu.read(7'h00, gm[5]);
		i_pmm_cpu.write(7'h00, 8'h5a);
		i_pmm_cpu.read(7'h45, 8'h5a);
		i_pmm_cpu.write(7'h04, 8'hf5);
		i_pmm_cpu.read(7'h00, gm[53]);
		i_pmm_cpu.write(7'h04, 8'h00);
		i_pmm_cpu.read(7'h00, 8'h00);
		i_pmm_cpu.write_read(7'h50, 8'($urandom));
		// program counter
		i_pmm_cpu.pc_op(1'b0, 1'b0, 11'h000, 1'b1, 13'h0004);
		i_pmm_cpu.pc_op(1'b1, 1'b0, 11'h000, 1'b0, 13'h0005);
		i_pmm_cpu.write(7'h0a, 8'h18);
		i_pmm_cpu.pc_op(1'b0, 1'b1, 11'h7ff, 1'b0, 13'h1fff);
		i_pmm_cpu.pc_op(1'b1, 1'b0, 11'h000, 1'b0, 13'h0000);
		i_pmm_cpu.write(7'h0a, 8'h0f);
		i_pmm_cpu.write(7'h02, 8'haa);
		i_pmm_cpu.pc_op(1'b0, 1'b0, 11'h000, 1'b0, 13'h0faa);
		i_pmm_cpu.pc_op(1'b1, 1'b1, 11'h123, 1'b1, 13'h0004);
		i_pmm_cpu.pc_op(1'b0, 1'b1, 11'h123, 1'b0, 13'h0923);
		// second reset: registers return, storage stays
		i_pmm_cpu.hold_reset();
		@(negedge clk_i);
		cmp_byte(status, 8'h18);
		cmp_byte(int_ctrl, 8'h00);
		i_pmm_cpu.pc_op(1'b0, 1'b0, 11'h000, 1'b0, 13'h0000);
		i_pmm_cpu.read(7'h03, 8'h18);
		i_pmm_cpu.read(7'h40, gm[0]);
		repeat (3) @(posedge clk_i);
		complete_run();
	end
endmodule : pmm_top_bench
`default_nettype wire
